// ### pkg/mirl_pkg.sv
// Shared constants and types of the interrupt request logic
`default_nettype none
package mirl_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  // Source counts
  localparam int unsigned NUM_TM        = 3;
  localparam int unsigned NUM_MF        = 3;
  localparam int unsigned NUM_UART_COND = 6;
  localparam int unsigned NUM_FLAGS     = 15;
  localparam int unsigned NUM_VEC       = 8;
  localparam int unsigned VEC_W         = 3;
  // Positions of request flags in the flag vector
  localparam int unsigned FL_SERIAL     = 0;
  localparam int unsigned FL_NV         = 1;
  localparam int unsigned FL_UART       = 2;
  localparam int unsigned FL_TB0        = 3;
  localparam int unsigned FL_TB1        = 4;
  localparam int unsigned FL_MF0        = 5;
  localparam int unsigned FL_TPM0       = 8;
  localparam int unsigned FL_TSM0       = 11;
  localparam int unsigned FL_LVD        = 14;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TM_EN    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLAG_SET = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TBC      = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h18;
  // Enable register fields
  localparam int unsigned EN_W          = 9;
  localparam int unsigned EN_SERIAL     = 0;
  localparam int unsigned EN_NV         = 1;
  localparam int unsigned EN_UART       = 2;
  localparam int unsigned EN_TB0        = 3;
  localparam int unsigned EN_TB1        = 4;
  localparam int unsigned EN_MF0        = 5;
  localparam int unsigned EN_LVD        = 8;
  localparam int unsigned TM_EN_W       = 6;
  localparam int unsigned TM_EN_SEC0    = 3;
  // Status register fields
  localparam int unsigned ST_BUSY_BIT   = 4;
  localparam int unsigned ST_UART_LSB   = 8;
  // Time-base control fields and reset value
  localparam logic [7:0]  TBC_RESET     = 8'h37;
  localparam int unsigned TBC_RUN       = 7;
  localparam int unsigned TBC_CLK_SEL   = 6;
  localparam int unsigned TBC_T1_LSB    = 4;
  localparam int unsigned TBC_SLOW_CRYSTAL_LOW_POWER     = 3;
  localparam int unsigned TBC_T0_LSB    = 0;
  localparam int unsigned TICK0_SEL_W   = 3;
  localparam int unsigned TICK1_SEL_W   = 2;
  localparam int unsigned TICK0_LOG2    = 8;
  localparam int unsigned TICK1_LOG2    = 12;
  localparam int unsigned TICK_CNT_W    = 15;
  localparam int unsigned PRESCALE_W    = 2;
  // Vector numbers, lowest number served first
  localparam logic [VEC_W-1:0] VEC_MF0    = 3'h0;
  localparam logic [VEC_W-1:0] VEC_MF2    = 3'h2;
  localparam logic [VEC_W-1:0] VEC_SERIAL = 3'h3;
  localparam logic [VEC_W-1:0] VEC_NV     = 3'h4;
  localparam logic [VEC_W-1:0] VEC_UART   = 3'h5;
  localparam logic [VEC_W-1:0] VEC_TB0    = 3'h6;
  localparam logic [VEC_W-1:0] VEC_TB1    = 3'h7;
  // Service sequencer states
  typedef enum logic [0:0] {ST_IDLE, ST_CALL} mirl_svc_state_t;
endpackage
`default_nettype wire

// ### logic/mirl_flag_bank.sv
// Bank of sticky request flags with hardware and software set and clear
`default_nettype none
`timescale 1ns/10ps
module mirl_flag_bank #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] hw_set_i,
  input  wire logic [W-1:0] hw_clr_i,
  input  wire logic [W-1:0] sw_set_i,
  input  wire logic [W-1:0] sw_clr_i,
  output logic      [W-1:0] flags_o,
  output logic      [W-1:0] rise_o
);
  import mirl_pkg::*;

  typedef struct packed {
    logic [W-1:0] flags;
    logic [W-1:0] rise;
  } mirl_bank_state_t;

  mirl_bank_state_t st_r;
  mirl_bank_state_t st_nxt;

  // Sets win over clears; rise marks low-to-high changes
  always_comb begin
    st_nxt       = st_r;
    st_nxt.flags = (st_r.flags & ~(hw_clr_i | sw_clr_i)) | hw_set_i | sw_set_i;
    st_nxt.rise  = st_nxt.flags & ~st_r.flags;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags_o = st_r.flags;
  assign rise_o  = st_r.rise;

  a_set_wins: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (|hw_set_i) |=> ((flags_o & $past(hw_set_i)) == $past(hw_set_i)))
    else $error("hardware set lost against a clear");
endmodule // mirl_flag_bank
`default_nettype wire

// ### logic/mirl_tick_div.sv
// Time-base divider producing the two periodic tick pulses
`default_nettype none
`timescale 1ns/10ps
module mirl_tick_div (
  input  wire logic                             core_clk_i,
  input  wire logic                             nrst_i,
  input  wire logic                             src_tick_i,
  input  wire logic                             run_i,
  input  wire logic [mirl_pkg::TICK0_SEL_W-1:0] tick0_sel_i,
  input  wire logic [mirl_pkg::TICK1_SEL_W-1:0] tick1_sel_i,
  output logic                                  tick0_o,
  output logic                                  tick1_o
);
  import mirl_pkg::*;

  typedef struct packed {
    logic [TICK_CNT_W-1:0] cnt;
    logic                  tick0;
    logic                  tick1;
  } mirl_div_state_t;

  mirl_div_state_t       st_r;
  mirl_div_state_t       st_nxt;
  logic [3:0]            shamt0;
  logic [3:0]            shamt1;
  logic [TICK_CNT_W:0]   full0;
  logic [TICK_CNT_W:0]   full1;
  logic [TICK_CNT_W-1:0] mask0;
  logic [TICK_CNT_W-1:0] mask1;

  // Ratio masks 2^8..2^15 and 2^12..2^15
  always_comb begin
    shamt0 = 4'(TICK0_LOG2) + {1'b0, tick0_sel_i};
    shamt1 = 4'(TICK1_LOG2) + {2'b00, tick1_sel_i};
    full0  = (TICK_CNT_W+1)'(1) << shamt0;
    full1  = (TICK_CNT_W+1)'(1) << shamt1;
    mask0  = TICK_CNT_W'(full0 - (TICK_CNT_W+1)'(1));
    mask1  = TICK_CNT_W'(full1 - (TICK_CNT_W+1)'(1));
  end

  // Free counter of source ticks; a tick fires on each rollover
  always_comb begin
    st_nxt       = st_r;
    st_nxt.tick0 = 1'b0;
    st_nxt.tick1 = 1'b0;
    if (!run_i) begin
      st_nxt.cnt = '0;
    end else if (src_tick_i) begin
      st_nxt.cnt   = TICK_CNT_W'(st_r.cnt + 1'b1);
      st_nxt.tick0 = ((st_r.cnt & mask0) == mask0);
      st_nxt.tick1 = ((st_r.cnt & mask1) == mask1);
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick0_o = st_r.tick0;
  assign tick1_o = st_r.tick1;

  a_tick0_period: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    tick0_o |-> ($past(st_r.cnt[7:0]) == 8'hff) && $past(src_tick_i))
    else $error("tick0 fired off a 2^8 boundary");
  a_tick1_period: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    tick1_o |-> ($past(st_r.cnt[11:0]) == 12'hfff) && $past(src_tick_i))
    else $error("tick1 fired off a 2^12 boundary");
endmodule // mirl_tick_div
`default_nettype wire

// ### logic/mirl_irq_core.sv
// Interrupt request, vectoring and wake-up logic with APB registers
// Functional notes
// - Serial flag set per byte sent/received
// - Serial call: global, serial enable, stack ok
// - Serial service clears its flag and global
// - Nonvolatile flag set when write completes
// - Nonvolatile call: global, enable, stack ok
// - Nonvolatile service clears flag and global
// - Two timer flags per timer, two enables
// - Timer call via grouped flag, three enables
// - Timer service clears grouped flag and global only
// - Low supply flag routes via grouped interrupt
// - Low supply flag survives service; software clears
// - Six UART conditions raise UART request
// - UART call: global, UART enable, stack ok
// - Sleep: any flag rise wakes, enables ignored
// - Three grouped flags set by contained sources
// - Return-from-irq sets global; plain return not
//
// Chosen here: the register addresses and the APB register port.
`default_nettype none
`timescale 1ns/10ps
module mirl_irq_core (
  input  wire logic                                core_clk_i,
  input  wire logic                                nrst_i,
  input  wire logic                                psel_i,
  input  wire logic                                penable_i,
  input  wire logic                                pwrite_i,
  input  wire logic [mirl_pkg::ADDR_W-1:0]         paddr_i,
  input  wire logic [mirl_pkg::DATA_W-1:0]         pwdata_i,
  output logic      [mirl_pkg::DATA_W-1:0]         prdata_o,
  output logic                                     pready_o,
  output logic                                     pslverr_o,
  input  wire logic                                serial_byte_done_i,
  input  wire logic                                nv_write_done_i,
  input  wire logic [mirl_pkg::NUM_TM-1:0]         timer_period_match_i,
  input  wire logic [mirl_pkg::NUM_TM-1:0]         timer_second_match_i,
  input  wire logic                                low_supply_detect_i,
  input  wire logic [mirl_pkg::NUM_UART_COND-1:0]  serial_port_cond_i,
  input  wire logic                                tbc_tick_i,
  input  wire logic                                stack_full_i,
  input  wire logic                                vec_ack_i,
  input  wire logic                                return_from_irq_i,
  input  wire logic                                plain_return_i,
  input  wire logic                                sleep_i,
  output logic                                     vec_req_o,
  output logic      [mirl_pkg::VEC_W-1:0]          vec_code_o,
  output logic                                     global_irq_enable_o,
  output logic                                     slow_crystal_low_power_o,
  output logic                                     wake_o
);
  import mirl_pkg::*;

  typedef struct packed {
    mirl_svc_state_t       state;
    logic                  gie;
    logic [EN_W-1:0]       en;
    logic [TM_EN_W-1:0]    tm_en;
    logic [7:0]            time_base_control;
    logic [VEC_W-1:0]      vec_code;
    logic [DATA_W-1:0]     prdata;
    logic [PRESCALE_W-1:0] prescale;
    logic                  uart_any;
    logic                  lvd_prev;
    logic                  wake;
  } mirl_core_state_t;

  mirl_core_state_t       st_r;
  mirl_core_state_t       st_nxt;
  logic [NUM_FLAGS-1:0]   flags;
  logic [NUM_FLAGS-1:0]   rise;
  logic [NUM_FLAGS-1:0]   hw_set;
  logic [NUM_FLAGS-1:0]   hw_clr;
  logic [NUM_FLAGS-1:0]   sw_set;
  logic [NUM_FLAGS-1:0]   sw_clr;
  logic [NUM_VEC-1:0]     req_vec;
  logic [NUM_MF-1:0]      mf_set;
  logic [VEC_W-1:0]       pick;
  logic                   src_tick;
  logic                   tick0;
  logic                   tick1;
  logic                   setup_ph;
  logic                   wr_acc;
  logic                   addr_hit;
  logic [DATA_W-1:0]      rd_mux;
  logic                   ack_ok;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // APB phase decode; zero wait states
  assign setup_ph  = psel_i & ~penable_i;
  assign wr_acc    = psel_i & penable_i & pwrite_i;
  assign addr_hit  = (paddr_i == OFS_CTRL) | (paddr_i == OFS_ENABLE) |
                     (paddr_i == OFS_TM_EN) | (paddr_i == OFS_FLAGS) |
                     (paddr_i == OFS_FLAG_SET) | (paddr_i == OFS_TBC) |
                     (paddr_i == OFS_STATUS);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_hit;

  // Read data mux
  always_comb begin
    rd_mux = '0;
    case (paddr_i)
      OFS_CTRL:     rd_mux[0] = st_r.gie;
      OFS_ENABLE:   rd_mux[EN_W-1:0] = st_r.en;
      OFS_TM_EN:    rd_mux[TM_EN_W-1:0] = st_r.tm_en;
      OFS_FLAGS:    rd_mux[NUM_FLAGS-1:0] = flags;
      OFS_TBC:      rd_mux[7:0] = st_r.time_base_control;
      OFS_STATUS: begin
        rd_mux[VEC_W-1:0]   = st_r.vec_code;
        rd_mux[ST_BUSY_BIT] = (st_r.state == ST_CALL);
        rd_mux[ST_UART_LSB +: NUM_UART_COND] = serial_port_cond_i;
      end
      default:      rd_mux = '0;
    endcase
  end

  // Software writes to the flag register: one clears, the set register sets
  always_comb begin
    sw_clr = '0;
    sw_set = '0;
    if (wr_acc && paddr_i == OFS_FLAGS) begin
      sw_clr = pwdata_i[NUM_FLAGS-1:0];
    end
    if (wr_acc && paddr_i == OFS_FLAG_SET) begin
      sw_set = pwdata_i[NUM_FLAGS-1:0];
    end
  end

  // Grouped flags: set when a contained, enabled source rises
  always_comb begin
    for (int n = 0; n < NUM_MF; n++) begin
      mf_set[n] = (rise[FL_TPM0+n] & st_r.tm_en[n]) |
                  (rise[FL_TSM0+n] & st_r.tm_en[TM_EN_SEC0+n]);
    end
    mf_set[NUM_MF-1] = mf_set[NUM_MF-1] | (rise[FL_LVD] & st_r.en[EN_LVD]);
  end

  // Hardware sets of the request flags
  always_comb begin
    hw_set            = '0;
    hw_set[FL_SERIAL] = serial_byte_done_i;
    hw_set[FL_NV]     = nv_write_done_i;
    hw_set[FL_UART]   = (|serial_port_cond_i) & ~st_r.uart_any;
    hw_set[FL_TB0]    = tick0;
    hw_set[FL_TB1]    = tick1;
    hw_set[FL_MF0 +: NUM_MF]  = mf_set;
    hw_set[FL_TPM0 +: NUM_TM] = timer_period_match_i;
    hw_set[FL_TSM0 +: NUM_TM] = timer_second_match_i;
    hw_set[FL_LVD]    = low_supply_detect_i & ~st_r.lvd_prev;
  end

  // Vector requests, each gated by global enable and stack room
  always_comb begin
    req_vec = '0;
    for (int n = 0; n < NUM_MF; n++) begin
      req_vec[VEC_MF0 + VEC_W'(n)] = st_r.en[EN_MF0+n] & flags[FL_MF0+n];
    end
    req_vec[VEC_SERIAL] = st_r.en[EN_SERIAL] & flags[FL_SERIAL];
    req_vec[VEC_NV]     = st_r.en[EN_NV] & flags[FL_NV];
    req_vec[VEC_UART]   = st_r.en[EN_UART] & flags[FL_UART];
    req_vec[VEC_TB0]    = st_r.en[EN_TB0] & flags[FL_TB0];
    req_vec[VEC_TB1]    = st_r.en[EN_TB1] & flags[FL_TB1];
    req_vec = req_vec & {NUM_VEC{st_r.gie & ~stack_full_i}};
  end

  // Lowest pending vector number wins
  always_comb begin
    pick = '0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (req_vec[i]) begin
        pick = VEC_W'(i);
      end
    end
  end

  // Flag cleared by the processor taking the call
  assign ack_ok = (st_r.state == ST_CALL) & vec_ack_i;
  always_comb begin
    hw_clr = '0;
    if (ack_ok) begin
      case (st_r.vec_code)
        VEC_SERIAL: hw_clr[FL_SERIAL] = 1'b1;
        VEC_NV:     hw_clr[FL_NV] = 1'b1;
        VEC_UART:   hw_clr[FL_UART] = 1'b1;
        VEC_TB0:    hw_clr[FL_TB0] = 1'b1;
        VEC_TB1:    hw_clr[FL_TB1] = 1'b1;
        default:    hw_clr[FL_MF0 + int'(st_r.vec_code)] = 1'b1;
      endcase
    end
  end

  // Time-base source: external tick or system clock over four
  assign src_tick = st_r.time_base_control[TBC_CLK_SEL] ? (&st_r.prescale) : tbc_tick_i;

  // Next-state logic: registers, service sequencer, wake
  always_comb begin
    st_nxt          = st_r;
    st_nxt.prescale = PRESCALE_W'(st_r.prescale + 1'b1);
    st_nxt.uart_any = |serial_port_cond_i;
    st_nxt.lvd_prev = low_supply_detect_i;
    st_nxt.wake     = sleep_i & (|rise);
    if (setup_ph) begin
      st_nxt.prdata = rd_mux;
    end
    if (wr_acc) begin
      case (paddr_i)
        OFS_CTRL:   st_nxt.gie = pwdata_i[0];
        OFS_ENABLE: st_nxt.en = pwdata_i[EN_W-1:0];
        OFS_TM_EN:  st_nxt.tm_en = pwdata_i[TM_EN_W-1:0];
        OFS_TBC:    st_nxt.time_base_control = pwdata_i[7:0];
        default:    st_nxt.time_base_control = st_r.time_base_control;
      endcase
    end
    case (st_r.state)
      ST_IDLE: begin
        if (|req_vec) begin
          st_nxt.vec_code = pick;
          st_nxt.state    = ST_CALL;
        end
      end
      ST_CALL: begin
        if (vec_ack_i) begin
          st_nxt.gie   = 1'b0;
          st_nxt.state = ST_IDLE;
        end else if (!st_r.gie) begin
          st_nxt.state = ST_IDLE;
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase
    if (return_from_irq_i) begin
      st_nxt.gie = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r       <= '0;
      st_r.state <= ST_IDLE;
      st_r.time_base_control   <= TBC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  mirl_flag_bank #(.W(NUM_FLAGS)) u_flags (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .hw_set_i   (hw_set),
    .hw_clr_i   (hw_clr),
    .sw_set_i   (sw_set),
    .sw_clr_i   (sw_clr),
    .flags_o    (flags),
    .rise_o     (rise)
  );

  mirl_tick_div u_div (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .src_tick_i  (src_tick),
    .run_i       (st_r.time_base_control[TBC_RUN]),
    .tick0_sel_i (st_r.time_base_control[TBC_T0_LSB +: TICK0_SEL_W]),
    .tick1_sel_i (st_r.time_base_control[TBC_T1_LSB +: TICK1_SEL_W]),
    .tick0_o     (tick0),
    .tick1_o     (tick1)
  );

  // Outputs from state
  assign prdata_o                 = st_r.prdata;
  assign vec_req_o                = (st_r.state == ST_CALL);
  assign vec_code_o               = st_r.vec_code;
  assign global_irq_enable_o      = st_r.gie;
  assign slow_crystal_low_power_o = st_r.time_base_control[TBC_SLOW_CRYSTAL_LOW_POWER];
  assign wake_o                   = st_r.wake;

  // Checks
  sequence s_ack(logic [VEC_W-1:0] v);
    vec_req_o && vec_ack_i && (vec_code_o == v) && !return_from_irq_i;
  endsequence

  a_serial_sets: assert property (serial_byte_done_i |=> flags[FL_SERIAL])
    else $error("serial byte event did not set flag");
  a_nv_sets: assert property (nv_write_done_i |=> flags[FL_NV])
    else $error("nonvolatile write end did not set flag");
  a_call_gated: assert property ($rose(vec_req_o) |-> $past(st_r.gie && !stack_full_i))
    else $error("call raised without global enable or stack room");
  a_serial_service: assert property (s_ack(VEC_SERIAL) ##0 !serial_byte_done_i
    |=> !global_irq_enable_o && !flags[FL_SERIAL])
    else $error("serial service left flag or global enable set");
  a_group_keeps: assert property (s_ack(VEC_MF2) ##0 flags[FL_LVD]
    |=> flags[FL_LVD] && !global_irq_enable_o)
    else $error("grouped service cleared the low supply flag");
  a_return_from_irq_sets: assert property (return_from_irq_i |=> global_irq_enable_o)
    else $error("return-from-irq did not set global enable");
  a_plain_ret: assert property (plain_return_i && !return_from_irq_i && !global_irq_enable_o
    && !(wr_acc && paddr_i == OFS_CTRL) |=> !global_irq_enable_o)
    else $error("plain return changed global enable");
  a_wake_rise: assert property (sleep_i && (|rise) |=> wake_o ##1 1'b1)
    else $error("flag rise in sleep did not wake");
  a_prio_low: assert property ($rose(vec_req_o) |->
    ($past(req_vec) & ((NUM_VEC)'(1) << vec_code_o) - (NUM_VEC)'(1)) == '0)
    else $error("higher vector chosen over lower pending one");
endmodule // mirl_irq_core
`default_nettype wire

// ### verification/mirl_cpu_model.sv
// Processor sequencer model: takes vector calls and returns from them
`default_nettype none
`timescale 1ns/10ps
module mirl_cpu_model #(
  parameter int unsigned ACK_DLY = 2
) (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic vec_req_i,
  input  wire logic use_return_from_irq_i,
  output logic      vec_ack_o,
  output logic      return_from_irq_o,
  output logic      ret_o
);
  int unsigned cnt;
  logic        in_isr;
  // Takes a call after a delay, runs a short handler, then returns
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt       <= 0;
      in_isr    <= 1'b0;
      vec_ack_o <= 1'b0;
      return_from_irq_o    <= 1'b0;
      ret_o     <= 1'b0;
    end else begin
      vec_ack_o <= 1'b0;
      return_from_irq_o    <= 1'b0;
      ret_o     <= 1'b0;
      cnt       <= (in_isr || vec_req_i) ? cnt + 1 : 0;
      if (!in_isr && vec_req_i && !vec_ack_o && cnt >= ACK_DLY) begin
        vec_ack_o <= 1'b1;
        in_isr    <= 1'b1;
        cnt       <= 0;
      end else if (in_isr && cnt == 4) begin
        return_from_irq_o    <= use_return_from_irq_i;  // Return kind chosen by the bench
        ret_o     <= !use_return_from_irq_i;
        in_isr    <= 1'b0;
        cnt       <= 0;
      end
    end
  end
endmodule // mirl_cpu_model
`default_nettype wire

// ### verification/mcu_interrupt_request_logic_bench.sv
// Self-checking bench of the interrupt request logic
`default_nettype none
`timescale 1ns/10ps
module mcu_interrupt_request_logic_bench;
  import mirl_pkg::*;
  typedef struct {int s; logic [31:0] en, tm; logic [2:0] code; logic [31:0] left;} mirl_row_t;
  logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, sbd = 0, nvd = 0, lsd = 0;
  logic        tick = 0, stk = 0, slp = 0, return_from_irq_on = 0, tick_on = 0, rerr;
  logic        prdy, perr, ack, return_from_irq, ret, vreq, gie, lp, wake;
  logic [7:0]  pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic [2:0]  tpm = 0, tsm = 0, code;
  logic [5:0]  uc = 0;
  wire  logic [4:0] ev;
  int          err_total = 0, checked = 0, ticks = 0, t0, cyc = 0;
  mirl_row_t   rows [6] = '{'{0, 32'h001, 32'h00, 3'h3, 32'h0000}, '{1, 32'h002, 32'h00, 3'h4, 0},
    '{2, 32'h004, 32'h00, 3'h5, 0}, '{3, 32'h020, 32'h01, 3'h0, 32'h0100},
    '{4, 32'h040, 32'h10, 3'h1, 32'h1000}, '{5, 32'h180, 32'h00, 3'h2, 32'h4000}};
  assign ev = {wake, ret, return_from_irq, ack, vreq};
  mirl_irq_core i_dut (
    .core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .serial_byte_done_i(sbd), .nv_write_done_i(nvd), .timer_period_match_i(tpm),
    .timer_second_match_i(tsm), .low_supply_detect_i(lsd), .serial_port_cond_i(uc),
    .tbc_tick_i(tick), .stack_full_i(stk), .vec_ack_i(ack), .return_from_irq_i(return_from_irq),
    .plain_return_i(ret), .sleep_i(slp), .vec_req_o(vreq), .vec_code_o(code),
    .global_irq_enable_o(gie), .slow_crystal_low_power_o(lp), .wake_o(wake));
  mirl_cpu_model i_cpu (.core_clk_i(clk), .nrst_i(nrst), .vec_req_i(vreq),
    .use_return_from_irq_i(return_from_irq_on), .vec_ack_o(ack), .return_from_irq_o(return_from_irq), .ret_o(ret));
  // Clock and time-base tick source
  always #10 clk = ~clk;
  always @(posedge clk) begin
    tick <= tick_on & ~tick;
    if (tick) ticks <= ticks + 1;
    cyc <= cyc + 1;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_on(input int w, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ev[w] !== 1'b1 && n < lim);
    check("event", ev[w], 1);
  endtask
  task automatic pulse(input int s);
    case (s)
      0: sbd <= 1'b1;
      1: nvd <= 1'b1;
      2: uc <= 6'h04;
      3: tpm <= 3'h1;
      4: tsm <= 3'h2;
      default: lsd <= 1'b1;
    endcase
    @(posedge clk);
    sbd <= 1'b0;
    nvd <= 1'b0;
    tpm <= 3'h0;
    tsm <= 3'h0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog against a hung wait
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check("vreq", vreq, 0);
    check("gie", gie, 0);
    check("lp", lp, 0);
    check("pready", prdy, 1);
    apb(0, OFS_TBC, 0);
    check("tbc", rd, {24'h0, TBC_RESET});
    apb(1, OFS_TBC, 32'h08);
    check("lp", lp, 1);
    apb(0, 8'h1c, 0);
    check("slverr", rerr, 1);
    check("unmapped", rd, 0);
    // Call held off by a full stack while global enable is set, then taken
    apb(1, OFS_ENABLE, 32'h1);
    pulse(0);
    stk <= 1'b1;
    apb(1, OFS_CTRL, 1);
    repeat (3) @(posedge clk);
    check("blocked", vreq, 0);
    stk <= 1'b0;
    wait_on(0, 10);
    check("code", code, VEC_SERIAL);
    wait_on(3, 20);
    // One source per row: call, service, flags left behind
    foreach (rows[i]) begin
      apb(1, OFS_FLAGS, 32'h7fff); // Software clears leftover flags
      apb(1, OFS_ENABLE, rows[i].en);
      apb(1, OFS_TM_EN, rows[i].tm);
      apb(1, OFS_CTRL, 1);
      pulse(rows[i].s);
      wait_on(0, 10);
      check("code", code, rows[i].code);
      wait_on(3, 20);
      @(posedge clk);
      check("gie", gie, 0);
      apb(0, OFS_FLAGS, 0);
      check("flags", rd, rows[i].left);
      uc <= 6'h0;
      lsd <= 1'b0;
    end
    // Each UART condition alone raises the UART flag
    for (int k = 0; k < 6; k++) begin
      apb(1, OFS_FLAGS, 32'h7fff);
      uc <= 6'h1 << k;
      @(posedge clk);
      uc <= 6'h0;
      apb(0, OFS_FLAGS, 0);
      check("uart", rd[FL_UART], 1);
    end
    // Two requests at once, served in vector order with return-from-irq
    return_from_irq_on <= 1'b1;
    apb(1, OFS_FLAGS, 32'h7fff);
    apb(1, OFS_ENABLE, 32'h3);
    apb(1, OFS_CTRL, 1);
    nvd <= 1'b1;
    pulse(0);
    wait_on(0, 10);
    check("first", code, VEC_SERIAL);
    wait_on(2, 20);
    @(posedge clk);
    check("gie", gie, 1);
    wait_on(0, 10);
    check("second", code, VEC_NV);
    wait_on(2, 20);
    // Tick periods measured in time-base ticks between calls
    apb(1, OFS_FLAGS, 32'h7fff);
    apb(1, OFS_ENABLE, 32'h8);
    apb(1, OFS_TBC, 32'h80);
    tick_on <= 1'b1;
    wait_on(0, 2000);
    t0 = ticks;
    wait_on(2, 20);
    wait_on(0, 2000);
    check("tick0", ticks - t0, 256);
    wait_on(2, 20);
    apb(1, OFS_FLAGS, 32'h7fff);
    apb(1, OFS_ENABLE, 32'h10);
    wait_on(0, 9000);
    t0 = ticks;
    wait_on(2, 20);
    wait_on(0, 9000);
    check("tick1", ticks - t0, 4096);
    wait_on(2, 20);
    // Tick0 from system clock over four, ratio code 001, in clock cycles
    apb(1, OFS_TBC, 32'hc1);
    apb(1, OFS_FLAGS, 32'h7fff);
    apb(1, OFS_ENABLE, 32'h8);
    wait_on(0, 2500);
    t0 = cyc;
    wait_on(2, 20);
    wait_on(0, 2500);
    check("tick0_sys", cyc - t0, 2048);
    wait_on(2, 20);
    // Wake from sleep with enables off; a preset flag gives none
    tick_on <= 1'b0;
    apb(1, OFS_CTRL, 0);
    apb(1, OFS_ENABLE, 0);
    apb(1, OFS_FLAGS, 32'h7fff);
    slp <= 1'b1;
    pulse(1);
    wait_on(4, 6);
    slp <= 1'b0;
    apb(1, OFS_FLAG_SET, 32'h1); // Flag preset before sleep
    slp <= 1'b1;
    pulse(0);
    repeat (5) begin
      @(posedge clk);
      check("nowake", wake, 0);
    end
    // Reset in mid-run returns registers and flags to idle values
    slp <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check("gie", gie, 0);
    check("wake", wake, 0);
    apb(0, OFS_FLAGS, 0);
    check("flags", rd, 0);
    apb(0, OFS_TBC, 0);
    check("tbc", rd, {24'h0, TBC_RESET});
    finish_test();
  end
endmodule // mcu_interrupt_request_logic_bench
`default_nettype wire
